// >>> rtl/cag_pkg.sv
/*
  cag_pkg: constants, modes and carriers shared by the address generator
  and its vector table fetcher.
  Assumes a 16-bit byte address space and eight 8-bit working registers.
*/
package cag_pkg;

  localparam int          ADDR_W       = 16;
  localparam int          VIDX_LSB     = 1;        // vector index sits in opcode bits 1..5
  localparam int          VIDX_W       = 5;
  localparam logic [15:0] VEC_BASE     = 16'h0040; // first vector table byte
  localparam logic [15:0] VEC_LAST     = 16'h007f; // last vector table byte
  localparam logic [7:0]  SHORT_SPLIT  = 8'h20;    // short fields below this land in page ff
  localparam logic [6:0]  HIGH_ONES    = 7'h7f;    // effective address bits 15..9
  localparam logic [7:0]  SFR_PAGE     = 8'hff;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] STACK_STEP   = 16'h0001;
  localparam logic [1:0]  PAIR_ACC     = 2'h0;     // accumulator_pair = registers 1:0
  localparam logic [1:0]  PAIR_INDEX   = 2'h2;     // index_pair = registers 5:4
  localparam logic [1:0]  PAIR_BASE    = 2'h3;     // base_pair = registers 7:6

  typedef enum logic [3:0] {
    CAG_SEQ, CAG_BR_ABS, CAG_BR_TABLE, CAG_BR_REG, CAG_BR_REL,
    CAG_OP_DIRECT, CAG_OP_SHORT, CAG_OP_SFR, CAG_OP_REG8, CAG_OP_PAIR,
    CAG_OP_IND_INDEX, CAG_OP_IND_BASE, CAG_OP_BASED, CAG_OP_PUSH, CAG_OP_POP
  } cag_mode_t;

  typedef struct packed {
    cag_mode_t   mode;
    logic [7:0]  opcode;   // first instruction byte
    logic [15:0] imm16;    // absolute_target / direct operand
    logic [7:0]  imm8;     // short field, branch_displacement or offset
    logic [2:0]  length;   // byte length of the instruction
  } cag_req_t;

  typedef struct packed {
    logic [15:0] addr;      // effective address or new program counter
    logic [2:0]  reg_index; // byte register, or low byte of a pair
    logic        reg_sel;
    logic        pair_sel;
    logic        pc_write;
  } cag_res_t;

endpackage

// >>> rtl/cag_vector_fetch.sv
/*
  cag_vector_fetch: reads a 16-bit branch target from the vector table,
  low byte at the even address, then high byte at the next one.
  Assumes the memory answers each read with a one-cycle ack and data.
*/
`timescale 1ns/10ps
module cag_vector_fetch
  import cag_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              start_i,
  input  wire logic [VIDX_W-1:0] index_i,
  output logic                   mem_rd_o,
  output logic [15:0]            mem_addr_o,
  input  wire logic              mem_ack_i,
  input  wire logic [7:0]        mem_data_i,
  output logic                   done_o,
  output logic [15:0]            target_o
);

  typedef enum logic [1:0] {CAG_VF_IDLE, CAG_VF_LOW, CAG_VF_HIGH} cag_vf_state_t;

  cag_vf_state_t state, next_state;
  logic [15:0]   addr, next_addr;
  logic [7:0]    low, next_low;
  logic [15:0]   target, next_target;
  logic          done, next_done;

  // two reads per vector; the table never leaves 40h..7fh
  always_comb begin
    next_state  = state;
    next_addr   = addr;
    next_low    = low;
    next_target = target;
    next_done   = 1'b0;
    case (state)
      CAG_VF_IDLE: if (start_i) begin
        next_addr  = VEC_BASE + {10'h000, index_i, 1'b0};
        next_state = CAG_VF_LOW;
      end
      CAG_VF_LOW: if (mem_ack_i) begin
        next_low   = mem_data_i;
        next_addr  = addr + STACK_STEP;
        next_state = CAG_VF_HIGH;
      end
      CAG_VF_HIGH: if (mem_ack_i) begin
        next_target = {mem_data_i, low};
        next_done   = 1'b1;
        next_state  = CAG_VF_IDLE;
      end
      default: next_state = CAG_VF_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state  <= CAG_VF_IDLE;
      addr   <= VEC_BASE;
      low    <= 8'h00;
      target <= 16'h0000;
      done   <= 1'b0;
    end else begin
      state  <= next_state;
      addr   <= next_addr;
      low    <= next_low;
      target <= next_target;
      done   <= next_done;
    end
  end

  assign mem_rd_o   = (state != CAG_VF_IDLE);
  assign mem_addr_o = addr;
  assign done_o     = done;
  assign target_o   = target;

  a_vector_in_table: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_rd_o |-> (mem_addr_o >= VEC_BASE) && (mem_addr_o <= VEC_LAST))
    else $error("vector read outside table");

endmodule // cag_vector_fetch

// >>> rtl/cag_address_gen.sv
/*
  cag_address_gen: branch target and operand address generation.
  Assumes the sequencer holds req_i stable while req_valid_i is high and
  keeps the stack in internal ram and short word operands even.
*/
`timescale 1ns/10ps
module cag_address_gen
  import cag_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            reset_i,
  input  wire logic            req_valid_i,
  input  wire cag_req_t        req_i,
  output logic                 ready_o,
  input  wire logic [7:0][7:0] regs_i,
  input  wire logic [15:0]     stack_pointer_i,
  output logic                 mem_rd_o,
  output logic [15:0]          mem_addr_o,
  input  wire logic            mem_ack_i,
  input  wire logic [7:0]      mem_data_i,
  output logic                 done_o,
  output cag_res_t             result_o,
  output logic [15:0]          pc_o
);

  typedef enum logic {CAG_IDLE, CAG_VECTOR} cag_state_t;

  cag_state_t        state, next_state;
  logic [15:0]       pc, next_pc;
  cag_res_t          res, next_res;
  logic              done, next_done;
  logic              vec_start;
  logic              vec_done;
  logic [15:0]       vec_target;
  logic [3:0][15:0]  pair;
  logic              take;
  logic [15:0]       next_seq_pc;
  logic [15:0]       rel_target;
  logic [15:0]       short_addr;

  // register pairs are built from adjacent byte registers
  for (genvar p = 0; p < 4; p++) begin : g_pair
    assign pair[p] = {regs_i[2*p+1], regs_i[2*p]};
  end

  assign take        = req_valid_i && ready_o;
  assign ready_o     = (state == CAG_IDLE);
  // 16-bit sums drop the carry, so the space wraps silently
  assign next_seq_pc = pc + {13'h0000, req_i.length};
  assign rel_target  = next_seq_pc + {{8{req_i.imm8[7]}}, req_i.imm8};
  // bit 8 is the inverse of "field at or above 20h"
  assign short_addr  = {HIGH_ONES, (req_i.imm8 < SHORT_SPLIT), req_i.imm8};

  // decode of the request; table call parks in CAG_VECTOR until the fetch ends
  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_res   = res;
    next_done  = 1'b0;
    vec_start  = 1'b0;
    case (state)
      CAG_IDLE: if (take) begin
        next_res  = '0;
        next_done = 1'b1;
        case (req_i.mode)
          CAG_SEQ: begin
            next_pc       = next_seq_pc;
            next_res.addr = next_seq_pc;
          end
          CAG_BR_ABS: begin
            next_pc           = req_i.imm16;
            next_res.addr     = req_i.imm16;
            next_res.pc_write = 1'b1;
          end
          CAG_BR_TABLE: begin
            vec_start  = 1'b1;
            next_done  = 1'b0;
            next_state = CAG_VECTOR;
          end
          CAG_BR_REG: begin
            next_pc           = pair[PAIR_ACC];
            next_res.addr     = pair[PAIR_ACC];
            next_res.pc_write = 1'b1;
          end
          CAG_BR_REL: begin
            next_pc           = rel_target;
            next_res.addr     = rel_target;
            next_res.pc_write = 1'b1;
          end
          CAG_OP_DIRECT:    next_res.addr = req_i.imm16;
          // ram below ff00h, low sfrs above: both forms meet at ff00h..ff1fh
          CAG_OP_SHORT:     next_res.addr = short_addr;
          CAG_OP_SFR:       next_res.addr = {SFR_PAGE, req_i.imm8};
          CAG_OP_REG8: begin
            next_res.reg_sel   = 1'b1;
            next_res.reg_index = req_i.opcode[2:0];
          end
          CAG_OP_PAIR: begin
            next_res.pair_sel  = 1'b1;
            next_res.reg_index = {req_i.opcode[1:0], 1'b0};
          end
          CAG_OP_IND_INDEX: next_res.addr = pair[PAIR_INDEX];
          CAG_OP_IND_BASE:  next_res.addr = pair[PAIR_BASE];
          CAG_OP_BASED:     next_res.addr = pair[PAIR_BASE] + {8'h00, req_i.imm8};
          // push pre-decrements, pop uses the pointer as it stands
          CAG_OP_PUSH:      next_res.addr = stack_pointer_i - STACK_STEP;
          CAG_OP_POP:       next_res.addr = stack_pointer_i;
          default:          next_res.addr = 16'h0000;
        endcase
      end
      CAG_VECTOR: if (vec_done) begin
        next_pc           = vec_target;
        next_res.addr     = vec_target;
        next_res.pc_write = 1'b1;
        next_done         = 1'b1;
        next_state        = CAG_IDLE;
      end
      default: next_state = CAG_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= CAG_IDLE;
      pc    <= RESET_PC;
      res   <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      pc    <= next_pc;
      res   <= next_res;
      done  <= next_done;
    end
  end

  assign done_o   = done;
  assign result_o = res;
  assign pc_o     = pc;

  // vector reads go out through this block's memory port
  cag_vector_fetch u_vector_fetch (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .start_i    (vec_start),
    .index_i    (req_i.opcode[VIDX_LSB +: VIDX_W]),
    .mem_rd_o   (mem_rd_o),
    .mem_addr_o (mem_addr_o),
    .mem_ack_i  (mem_ack_i),
    .mem_data_i (mem_data_i),
    .done_o     (vec_done),
    .target_o   (vec_target)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_take(cag_mode_t m);
    req_valid_i && ready_o && (req_i.mode == m);
  endsequence

  sequence s_vec_read_start;
    s_take(CAG_BR_TABLE) ##1 mem_rd_o && (mem_addr_o ==
      VEC_BASE + {10'h000, $past(req_i.opcode[VIDX_LSB +: VIDX_W]), 1'b0});
  endsequence

  a_abs_branch_pc: assert property (s_take(CAG_BR_ABS) |=>
    done_o && result_o.pc_write && (pc_o == $past(req_i.imm16)))
    else $error("absolute branch did not load target");

  a_table_vector_addr: assert property (s_take(CAG_BR_TABLE) |-> s_vec_read_start)
    else $error("vector read address wrong");

  a_table_pc_load: assert property (vec_done && (state == CAG_VECTOR) |=>
    done_o && (pc_o == $past(vec_target)) && ready_o)
    else $error("vector target not loaded");

  a_reg_branch_pc: assert property (s_take(CAG_BR_REG) |=>
    pc_o == {$past(regs_i[1]), $past(regs_i[0])})
    else $error("register branch wrong");

  a_direct_operand: assert property (s_take(CAG_OP_DIRECT) |=>
    done_o && (result_o.addr == $past(req_i.imm16)) && $stable(pc_o))
    else $error("direct address wrong");

  a_short_window: assert property (s_take(CAG_OP_SHORT) |=>
    (result_o.addr >= 16'hfe20) && (result_o.addr <= 16'hff1f) &&
    (result_o.addr[7:0] == $past(req_i.imm8)) &&
    (result_o.addr[8] == ($past(req_i.imm8) < SHORT_SPLIT)))
    else $error("short direct address wrong");

  a_sfr_page: assert property (s_take(CAG_OP_SFR) |=>
    result_o.addr == {SFR_PAGE, $past(req_i.imm8)})
    else $error("sfr address wrong");

  a_reg_select: assert property (s_take(CAG_OP_REG8) |=>
    result_o.reg_sel && !result_o.pair_sel && (result_o.reg_index == $past(req_i.opcode[2:0])))
    else $error("register select wrong");

  a_based_sum: assert property (s_take(CAG_OP_BASED) |=>
    result_o.addr == 16'($past(pair[PAIR_BASE]) + {8'h00, $past(req_i.imm8)}))
    else $error("based address wrong");

  a_stack_push: assert property (s_take(CAG_OP_PUSH) |=>
    result_o.addr == 16'($past(stack_pointer_i) - STACK_STEP))
    else $error("push address wrong");

  a_rel_branch: assert property (s_take(CAG_BR_REL) |=>
    pc_o == 16'($past(pc) + $past(req_i.length) + {{8{$past(req_i.imm8[7])}}, $past(req_i.imm8)}))
    else $error("relative branch wrong");

  a_seq_advance: assert property (s_take(CAG_SEQ) |=>
    !result_o.pc_write && (pc_o == 16'($past(pc) + $past(req_i.length))))
    else $error("sequential advance wrong");

endmodule // cag_address_gen

// >>> verification/cag_vec_mem_model.sv
/*
  cag_vec_mem_model: vector table memory on the fetch port of the
  address generator. Assumes each read is held until acked.
*/
`timescale 1ns/10ps
module cag_vec_mem_model (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [1:0]  wait_i,
  output logic             ack_o,
  output logic [7:0]       data_o
);
  logic [1:0] cnt;
  logic [7:0] noise;

  // combinational ack so a zero wait answers in the request cycle
  assign ack_o  = rd_i && (cnt == wait_i);
  // table byte pattern; junk that changes each cycle when not acking
  assign data_o = ack_o ? (addr_i[7:0] ^ 8'h5a) : noise;

  // wait counter, cleared on each ack
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt   <= 2'h0;
      noise <= 8'ha5;
    end else begin
      noise <= ~noise + 8'h01;
      cnt   <= (rd_i && !ack_o) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule // cag_vec_mem_model

// >>> verification/cag_address_gen_bench.sv
/*
  cag_address_gen_bench: self-checking bench for the address generator.
  Assumes the vector memory model sits on the fetch port.
*/
`timescale 1ns/10ps
module cag_address_gen_bench
  import cag_pkg::*;
();
  typedef struct packed {
    cag_req_t    req;
    logic [15:0] exp; // address, new pc or register index
  } cag_row_t;

  logic            clock_i, reset_i, req_valid_i, ready_o, mem_rd_o, mem_ack_i, done_o;
  cag_req_t        req_i;
  cag_res_t        result_o;
  logic [7:0][7:0] regs_i;
  logic [15:0]     stack_pointer_i, mem_addr_o, pc_o, pc_exp;
  logic [7:0]      mem_data_i;
  logic [1:0]      wait_cyc;
  logic [15:0]     ack_q[$];
  int              n_mismatch, compares;
  cag_row_t        rows[24];

  always #25 clock_i = ~clock_i;

  cag_address_gen i_cag_address_gen (.clock_i(clock_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .ready_o(ready_o), .regs_i(regs_i), .stack_pointer_i(stack_pointer_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
    .done_o(done_o), .result_o(result_o), .pc_o(pc_o));

  cag_vec_mem_model i_cag_vec_mem_model (.clock_i(clock_i), .reset_i(reset_i), .rd_i(mem_rd_o),
    .addr_i(mem_addr_o), .wait_i(wait_cyc), .ack_o(mem_ack_i), .data_o(mem_data_i));

  // every accepted vector read, in order; mid-cycle so no race with the launching edge
  always @(negedge clock_i) if (mem_rd_o && mem_ack_i) ack_q.push_back(mem_addr_o);

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // inputs move a fixed 2 ns after the edge
  task automatic step;
    @(posedge clock_i);
    #2;
  endtask

  function automatic cag_row_t rw(cag_mode_t m, logic [7:0] op, logic [15:0] i16, logic [7:0] i8,
                                  logic [15:0] e);
    return '{'{m, op, i16, i8, 3'h3}, e};
  endfunction

  // table call with a held request behind it that must wait
  task automatic table_call(input logic [4:0] idx, input logic [1:0] w);
    logic [15:0] va;
    va = 16'h0040 + {10'h0, idx, 1'b0};
    pc_exp = {(va[7:0] | 8'h01) ^ 8'h5a, va[7:0] ^ 8'h5a};
    wait_cyc = w;
    ack_q.delete();
    req_i = '{CAG_BR_TABLE, {2'h0, idx, 1'b0}, 16'h0, 8'h0, 3'h1};
    req_valid_i = 1'b1;
    step;
    cmp_bit(ready_o, 1'b0);
    req_i = '{CAG_SEQ, 8'h0, 16'h0, 8'h0, 3'h1};
    for (int i = 0; i < 20 && done_o !== 1'b1; i++) step;
    cmp_val(pc_o, pc_exp);
    cmp_bit(result_o.pc_write, 1'b1);
    cmp_val(ack_q[0], va);
    cmp_val(ack_q[1], va + 16'h1);
    step;
    req_valid_i = 1'b0;
    cmp_val(pc_o, pc_exp + 16'h1);
    step;
  endtask

  // watchdog far beyond the fifty or so cycles the run needs
  initial begin
    #50us;
    n_mismatch++;
    finish_test();
  end

  initial begin
    clock_i = 1'b0;
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    wait_cyc = 2'h0;
    n_mismatch = 0;
    compares = 0;
    pc_exp = 16'h0;
    regs_i = {8'hff, 8'hf0, 8'h12, 8'h34, 8'h02, 8'h01, 8'hab, 8'hcd};
    stack_pointer_i = 16'hfe80; // in ram, no short word operand sent
    rows = '{rw(CAG_SEQ, 0, 0, 0, 16'h0003), rw(CAG_BR_ABS, 0, 16'h1234, 0, 16'h1234),
      rw(CAG_BR_REL, 0, 0, 8'h80, 16'h11b7), rw(CAG_BR_REL, 0, 0, 8'h7f, 16'h1239),
      rw(CAG_BR_REG, 0, 0, 0, 16'habcd), rw(CAG_BR_ABS, 0, 16'hfffe, 0, 16'hfffe),
      rw(CAG_SEQ, 0, 0, 0, 16'h0001), rw(CAG_BR_REL, 0, 0, 8'hf0, 16'hfff4),
      rw(CAG_OP_DIRECT, 0, 16'hfe00, 0, 16'hfe00), rw(CAG_OP_SHORT, 0, 0, 8'h20, 16'hfe20),
      rw(CAG_OP_SHORT, 0, 0, 8'hff, 16'hfeff), rw(CAG_OP_SHORT, 0, 0, 8'h00, 16'hff00),
      rw(CAG_OP_SHORT, 0, 0, 8'h1f, 16'hff1f), rw(CAG_OP_SFR, 0, 0, 8'h00, 16'hff00),
      rw(CAG_OP_SFR, 0, 0, 8'hff, 16'hffff), rw(CAG_OP_IND_INDEX, 0, 0, 0, 16'h1234),
      rw(CAG_OP_IND_BASE, 0, 0, 0, 16'hfff0), rw(CAG_OP_BASED, 0, 0, 8'h20, 16'h0010),
      rw(CAG_OP_BASED, 0, 0, 8'h80, 16'h0070), rw(CAG_OP_PUSH, 0, 0, 0, 16'hfe7f),
      rw(CAG_OP_POP, 0, 0, 0, 16'hfe80), rw(CAG_OP_REG8, 8'h07, 0, 0, 16'h7),
      rw(CAG_OP_REG8, 8'h02, 0, 0, 16'h2), rw(CAG_OP_PAIR, 8'h03, 0, 0, 16'h6)};
    repeat (5) @(posedge clock_i);
    #2 reset_i = 1'b0;
    cmp_val(pc_o, 16'h0);
    cmp_bit(ready_o, 1'b1);
    // back to back, one request per cycle
    foreach (rows[i]) begin
      req_i = rows[i].req;
      req_valid_i = 1'b1;
      step;
      cmp_bit(done_o, 1'b1);
      if (rows[i].req.mode inside {CAG_OP_REG8, CAG_OP_PAIR}) begin
        cmp_val({13'h0, result_o.reg_index}, rows[i].exp);
        cmp_bit(rows[i].req.mode == CAG_OP_PAIR ? result_o.pair_sel : result_o.reg_sel, 1'b1);
      end else cmp_val(result_o.addr, rows[i].exp);
      if (rows[i].req.mode inside {CAG_SEQ, CAG_BR_ABS, CAG_BR_REG, CAG_BR_REL}) pc_exp = rows[i].exp;
      cmp_val(pc_o, pc_exp);
      cmp_bit(result_o.pc_write, rows[i].req.mode inside {CAG_BR_ABS, CAG_BR_REG, CAG_BR_REL});
    end
    req_valid_i = 1'b0;
    step;
    // table boundaries, prompt and slow memory
    table_call(5'h00, 2'h0);
    table_call(5'h1f, 2'h2);
    // reset in the middle of a slow table call
    req_i = '{CAG_BR_TABLE, 8'h04, 16'h0, 8'h0, 3'h1};
    req_valid_i = 1'b1;
    wait_cyc = 2'h3;
    step;
    req_valid_i = 1'b0;
    step;
    reset_i = 1'b1;
    #5;
    cmp_bit(ready_o, 1'b1);
    cmp_bit(done_o, 1'b0);
    cmp_bit(mem_rd_o, 1'b0);
    cmp_val(pc_o, 16'h0);
    cmp_val(mem_addr_o, 16'h0040);
    step;
    reset_i = 1'b0;
    req_i = '{CAG_SEQ, 8'h0, 16'h0, 8'h0, 3'h7};
    req_valid_i = 1'b1;
    step;
    req_valid_i = 1'b0;
    cmp_val(pc_o, 16'h0007);
    step;
    finish_test();
  end
endmodule // cag_address_gen_bench
